// *** hdl/wrt_watchdog_reset_timer.sv ***
// Watchdog reset timer: AHB-Lite register slave, unlock sequence,
// and the crossings to and from the oscillator-clocked counter.
// Assumes one AHB-Lite master, word transfers, and a watchdog
// oscillator clock that runs whenever the device is powered.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module wrt_watchdog_reset_timer
    import wrt_pkg::*;
#(
    parameter int TIMEOUT_BASE = wrt_pkg::TIMEOUT_BASE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        wdtOscClk,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        restartInstr,
    output logic             deviceReset,
    output logic             watchdogActive
);
    import wrt_pkg::*;

    wrt_bus_t          busState;
    wrt_bus_t          next_busState;
    logic              busHitCtrl;
    logic              busHitStat;
    wrt_ctrl_t         ctrl;
    wrt_ctrl_t         next_ctrl;
    logic [LEFT_W-1:0] unlockLeft;
    logic [LEFT_W-1:0] next_unlockLeft;
    logic              expirySeen;
    logic              next_expirySeen;
    logic [31:0]       next_hrdata;
    logic              ceOsc;
    logic              restartOsc;
    logic              expireOsc;
    logic              expireSys;

    // Byte image of the control register; upper bits fixed at zero
    function automatic logic [7:0] ctrlByte(input wrt_ctrl_t c);
        ctrlByte = {{RSV_W{1'b0}}, c};
    endfunction

    // Status image: window cycles left, window open, expiry seen
    function automatic logic [7:0] statByte(
        input logic [LEFT_W-1:0] left,
        input logic              open,
        input logic              seen
    );
        statByte = {3'h0, left, open, seen};
    endfunction

    // Address phase decode
    wire addrTake  = hsel & hready & htrans[1] & ce;
    wire addrCtrl  = (haddr == CTRL_ADDR);
    wire addrStat  = (haddr == STAT_ADDR);
    wire hsizeWord = (hsize == 3'h2);

    // Data phase decode; write data is valid in the data phase only
    wire writeNow  = (busState == BUS_WRITE) & ce;
    wire writeCtrl = writeNow & busHitCtrl;
    wire writeStat = writeNow & busHitStat;
    wrt_ctrl_t wrCtrl;
    assign wrCtrl  = hwdata[4:0];

    // Window ends on the fourth clock after the unlocking write
    wire unlockEnd = ctrl.unlock & (unlockLeft == '0);

    // Zero wait states; clock enable low stretches the data phase,
    // which freezes the bus together with the rest of the block
    assign hreadyout = ce;
    assign hresp     = HRESP_OKAY;

    // Next data phase
    always_comb begin
        if (addrTake) begin
            next_busState = hwrite ? BUS_WRITE : BUS_READ;
        end else begin
            next_busState = BUS_IDLE;
        end
    end

    // Enable and unlock; a write carrying unlock wins over the
    // self-clear in the same cycle
    always_comb begin
        next_ctrl = ctrl;
        if (writeCtrl) begin
            next_ctrl.sel = wrCtrl.sel;
            if (wrCtrl.on) begin
                next_ctrl.on = 1'b1;
            end else if (ctrl.unlock) begin
                next_ctrl.on = 1'b0;
            end
            next_ctrl.unlock = wrCtrl.unlock;
        end else if (unlockEnd) begin
            next_ctrl.unlock = 1'b0;
        end
    end

    // Countdown of the unlock window, reloaded on each unlocking write
    always_comb begin
        if (writeCtrl & wrCtrl.unlock) begin
            next_unlockLeft = UNLOCK_CYCLES - LEFT_W'(1);
        end else if (unlockLeft != '0) begin
            next_unlockLeft = unlockLeft - LEFT_W'(1);
        end else begin
            next_unlockLeft = unlockLeft;
        end
    end

    // Sticky expiry note; a new expiry wins over a write-one clear
    always_comb begin
        if (expireSys) begin
            next_expirySeen = 1'b1;
        end else if (writeStat & hwdata[0]) begin
            next_expirySeen = 1'b0;
        end else begin
            next_expirySeen = expirySeen;
        end
    end

    // Read data is built from next state so a read right after a
    // write to the same register already shows the written value
    always_comb begin
        if (addrTake & ~hwrite & addrCtrl & hsizeWord) begin
            next_hrdata = {24'h00_0000, ctrlByte(next_ctrl)};
        end else if (addrTake & ~hwrite & addrStat & hsizeWord) begin
            next_hrdata = {24'h00_0000,
                           statByte(next_unlockLeft, next_ctrl.unlock,
                                    next_expirySeen)};
        end else begin
            next_hrdata = 32'h0000_0000;
        end
    end

    // Bus tracking
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busState   <= BUS_IDLE;
            busHitCtrl <= 1'b0;
            busHitStat <= 1'b0;
            hrdata     <= 32'h0000_0000;
        end else if (ce) begin
            busState   <= next_busState;
            busHitCtrl <= addrTake & addrCtrl & hsizeWord;
            busHitStat <= addrTake & addrStat & hsizeWord;
            hrdata     <= next_hrdata;
        end
    end

    // Control state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl       <= CTRL_RESET;
            unlockLeft <= '0;
            expirySeen <= 1'b0;
        end else if (ce) begin
            ctrl       <= next_ctrl;
            unlockLeft <= next_unlockLeft;
            expirySeen <= next_expirySeen;
        end
    end

    // Device reset request, one clock long, only while enabled
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            deviceReset    <= 1'b0;
            watchdogActive <= 1'b0;
        end else if (ce) begin
            deviceReset    <= expireSys & ctrl.on;
            watchdogActive <= next_ctrl.on;
        end
    end

    // Restart instruction crosses to the oscillator clock as an event
    wrt_event_sync u_restartSync (
        .srcClk   (clk),
        .dstClk   (wdtOscClk),
        .rstn     (rstn),
        .srcEvent (restartInstr & ce),
        .dstEn    (ceOsc),
        .dstEvent (restartOsc)
    );

    // Counter lives on the oscillator; config crosses as a word
    wrt_osc_counter #(
        .TIMEOUT_BASE (TIMEOUT_BASE)
    ) u_counter (
        .oscClk  (wdtOscClk),
        .rstn    (rstn),
        .ceSys   (ce),
        .cfgSys  ({ctrl.on, ctrl.sel}),
        .restart (restartOsc),
        .ceOsc   (ceOsc),
        .expire  (expireOsc)
    );

    // Expiry returns to the system clock as an event
    wrt_event_sync u_expireSync (
        .srcClk   (wdtOscClk),
        .dstClk   (clk),
        .rstn     (rstn),
        .srcEvent (expireOsc),
        .dstEn    (ce),
        .dstEvent (expireSys)
    );
endmodule
`default_nettype wire

// *** common/wrt_pkg.sv ***
// Constants and types shared by the watchdog reset timer files.
// Assumes an AHB-Lite host on the system clock and a free-running
// watchdog oscillator that arrives as a second clock.
// How it works
// - Counter advances on its own oscillator clock
// - Restart instruction clears counter, new period
// - Enabled expiry without restart resets device
// - Bits 7..5 unwritable, always read zero
// - Enable clears only while unlock bit set
// - Unlock bit self-clears four clocks later
// - Enable one starts, accepted zero stops
// - Select codes give 16K to 2048K cycles
package wrt_pkg;

    // Register placement: index as printed, byte address is four times it
    localparam logic [7:0]  CTRL_INDEX = 8'h21;
    localparam logic [31:0] CTRL_ADDR  = {24'h00_0000, CTRL_INDEX} << 2;
    localparam logic [31:0] STAT_ADDR  = 32'h0000_0088;

    // Field layout
    localparam int SEL_W = 3;
    localparam int RSV_W = 3;
    localparam int LEFT_W = 3;

    // Control register fields, bit 4 down to bit 0
    typedef struct packed {
        logic             unlock;
        logic             on;
        logic [SEL_W-1:0] sel;
    } wrt_ctrl_t;

    // Configuration word that crosses into the oscillator domain
    typedef struct packed {
        logic             on;
        logic [SEL_W-1:0] sel;
    } wrt_cfg_t;

    // Data phase tracking, Gray along idle, write, read
    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ  = 2'b11
    } wrt_bus_t;

    // Reset values
    localparam wrt_ctrl_t CTRL_RESET = 5'h00;
    localparam wrt_cfg_t  CFG_RESET  = 4'h0;

    // Timing
    localparam logic [LEFT_W-1:0] UNLOCK_CYCLES = 3'h4;
    localparam int TIMEOUT_BASE_CYCLES = 32'h0000_4000;

    // Bus answers
    localparam logic HRESP_OKAY = 1'b0;

endpackage

// *** hdl/wrt_event_sync.sv ***
// Toggle crossing that carries single events between two clocks.
// Assumes events in the source domain are spaced wider than three
// destination clocks; two events within one destination clock cancel out.
`timescale 1ns/1ps
`default_nettype none
module wrt_event_sync (
    input  wire logic srcClk,
    input  wire logic dstClk,
    input  wire logic rstn,
    input  wire logic srcEvent,
    input  wire logic dstEn,
    output logic      dstEvent
);
    logic       srcToggle;
    logic [2:0] dstSync;

    // Source side flips a level per event
    always_ff @(posedge srcClk or negedge rstn) begin
        if (!rstn) begin
            srcToggle <= 1'b0;
        end else if (srcEvent) begin
            srcToggle <= ~srcToggle;
        end
    end

    // Stage 0 feeds stage 1 only; stages 1 and 2 form the edge detect
    always_ff @(posedge dstClk or negedge rstn) begin
        if (!rstn) begin
            dstSync <= 3'h0;
        end else if (dstEn) begin
            dstSync <= {dstSync[1:0], srcToggle};
        end
    end

    assign dstEvent = dstEn & (dstSync[2] ^ dstSync[1]);
endmodule
`default_nettype wire

// *** hdl/wrt_osc_counter.sv ***
// Timeout counter running on the watchdog oscillator clock.
// Assumes the configuration word changes rarely and the restart
// event arrives already on the oscillator clock.
`timescale 1ns/1ps
`default_nettype none
module wrt_osc_counter
    import wrt_pkg::*;
#(
    parameter int TIMEOUT_BASE = wrt_pkg::TIMEOUT_BASE_CYCLES,
    parameter int CNT_W        = $clog2(TIMEOUT_BASE) + 8
) (
    input  wire logic          oscClk,
    input  wire logic          rstn,
    input  wire logic          ceSys,
    input  wire wrt_pkg::wrt_cfg_t cfgSys,
    input  wire logic          restart,
    output logic               ceOsc,
    output logic               expire
);
    logic [1:0]       ceSync;
    wrt_cfg_t         cfgS1;
    wrt_cfg_t         cfgS2;
    wrt_cfg_t         cfgS3;
    wrt_cfg_t         cfg;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    // Period doubles with each select step
    wire [CNT_W-1:0] limit = CNT_W'(TIMEOUT_BASE) << cfg.sel;
    wire lastCount = (count == (limit - CNT_W'(1)));
    wire expireNow = cfg.on & lastCount & ~restart;

    assign ceOsc = ceSync[1];

    // Restart wins over counting; counter holds while disabled
    always_comb begin
        if (restart) begin
            next_count = '0;
        end else if (!cfg.on) begin
            next_count = count;
        end else if (lastCount) begin
            next_count = '0;
        end else begin
            next_count = count + CNT_W'(1);
        end
    end

    // Config bits are taken only once two settled samples agree,
    // so a skewed multi-bit change is never loaded half done
    always_ff @(posedge oscClk or negedge rstn) begin
        if (!rstn) begin
            ceSync <= 2'h0;
            cfgS1  <= CFG_RESET;
            cfgS2  <= CFG_RESET;
            cfgS3  <= CFG_RESET;
            cfg    <= CFG_RESET;
            count  <= '0;
            expire <= 1'b0;
        end else begin
            ceSync <= {ceSync[0], ceSys};
            cfgS1  <= cfgSys;
            cfgS2  <= cfgS1;
            cfgS3  <= cfgS2;
            if (ceOsc) begin
                if (cfgS2 == cfgS3) begin
                    cfg <= cfgS3;
                end
                count  <= next_count;
                expire <= expireNow;
            end else begin
                expire <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** dv/wrt_watchdog_reset_timer_properties.sv ***
// Concurrent checks on the watchdog reset timer top-level ports.
// Assumes a single AHB-Lite master whose hready is the slave's hreadyout.
`timescale 1ns/1ps
`default_nettype none
module wrt_watchdog_reset_timer_properties
    import wrt_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        ce,
    input wire logic        wdtOscClk,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        restartInstr,
    input wire logic        deviceReset,
    input wire logic        watchdogActive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic       wrPend;
    logic [2:0] unlockCnt;

    // Taken transfers; the oscillator side is judged by the bench timings
    wire        taken     = hsel && hready && htrans[1] && ce && (hsize == 3'b010);
    wire        takenCtlW = taken && hwrite && (haddr == CTRL_ADDR);
    wire        takenR    = taken && !hwrite;
    wire        dataEdge  = wrPend && hready;

    // Shadow of the unlock window, counted in enabled system clocks
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrPend    <= 1'b0;
            unlockCnt <= 3'h0;
        end else begin
            if (hready) wrPend <= takenCtlW;
            if (dataEdge) unlockCnt <= hwdata[4] ? 3'h4 : 3'h0;
            else if (ce && unlockCnt != 3'h0) unlockCnt <= unlockCnt - 3'h1;
        end
    end

    a_on_write_sets: assert property (dataEdge && hwdata[3] |=> watchdogActive)
        else $error("enable write did not activate");
    a_locked_stays_on: assert property (dataEdge && !hwdata[3] && watchdogActive && unlockCnt == 3'h0 |=> watchdogActive)
        else $error("locked watchdog was switched off");
    a_unlock_turns_off: assert property (dataEdge && !hwdata[3] && unlockCnt != 3'h0 |=> !watchdogActive)
        else $error("unlocked clear did not deactivate");
    a_active_by_write: assert property (!$stable(watchdogActive) |-> $past(dataEdge))
        else $error("active level moved without a write");
    a_rsv_read_zero: assert property (takenR && haddr == CTRL_ADDR |=> hrdata[31:5] == 27'h000_0000)
        else $error("reserved control bits read nonzero");
    a_unmapped_zero: assert property (takenR && haddr != CTRL_ADDR && haddr != STAT_ADDR |=> hrdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    a_reset_one_pulse: assert property (deviceReset |=> !deviceReset)
        else $error("device reset longer than one cycle");
    a_reset_needs_on: assert property (deviceReset |-> $past(watchdogActive))
        else $error("device reset while disabled");
    a_ready_follows: assert property (hreadyout == ce && hresp == HRESP_OKAY)
        else $error("ready or response wrong");
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the watchdog reset timer over AHB-Lite.
// Assumes a short TIMEOUT_BASE so every select code can be timed.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import wrt_pkg::*;
    localparam int BASE = 16;
    logic        clk, wdtOscClk, rstn, ce, hsel, hwrite, restartInstr, sawReset;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, deviceReset, watchdogActive;
    wire logic   hready;
    int          miscompares, n_checks, n;
    assign hready = hreadyout;

    wrt_watchdog_reset_timer #(.TIMEOUT_BASE(BASE)) u_wrt_watchdog_reset_timer (
        .clk(clk), .rstn(rstn), .ce(ce), .wdtOscClk(wdtOscClk), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .restartInstr(restartInstr),
        .deviceReset(deviceReset), .watchdogActive(watchdogActive));

    // System clock 100 ns; oscillator 90 ns with an odd offset so edges never meet
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        wdtOscClk = 1'b0;
        #13;
        forever #45 wdtOscClk = ~wdtOscClk;
    end
    always @(posedge clk) if (deviceReset === 1'b1) sawReset <= 1'b1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_win(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("[ERR] %0t delay %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // One single word transfer; read data is taken at the data-phase edge
    task automatic bus(input logic [31:0] adr, input logic wr, input logic [31:0] wd);
        int k;
        k = 0;
        haddr  <= adr;
        hwrite <= wr;
        htrans <= 2'b10;
        do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 50);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 50);
        rd = hrdata;
        if (k >= 50) begin
            miscompares++;
            $display("[ERR] %0t bus transfer never answered", $time);
        end
    endtask
    task automatic rd_chk(input logic [31:0] adr, input logic [31:0] exp);
        bus(adr, 1'b0, 32'h0000_0000);
        chk(rd, exp);
    endtask
    task automatic pulse_restart();
        restartInstr <= 1'b1;
        @(posedge clk);
        restartInstr <= 1'b0;
        @(posedge clk);
    endtask
    // Release on a system edge; the oscillator never has an edge there
    task automatic do_reset();
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        {rstn, ce, hsel, hwrite, restartInstr, sawReset} = 6'b010000;
        {haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
        miscompares = 0;
        n_checks = 0;
        hsel = 1'b1;
        @(posedge clk);
        do_reset();
        rd_chk(CTRL_ADDR, 32'h0000_0000);
        bus(32'h0000_0080, 1'b1, 32'h0000_00FF);
        rd_chk(32'h0000_0080, 32'h0000_0000);
        rd_chk(CTRL_ADDR, 32'h0000_0000);
        $display("test reset and map done");
        bus(CTRL_ADDR, 1'b1, 32'h0000_00FF);
        rd_chk(CTRL_ADDR, 32'h0000_001F);
        repeat (5) @(posedge clk);
        rd_chk(CTRL_ADDR, 32'h0000_000F);
        chk(watchdogActive, 1'b1);
        bus(CTRL_ADDR, 1'b1, 32'h0000_0007);
        rd_chk(CTRL_ADDR, 32'h0000_000F);
        bus(CTRL_ADDR, 1'b1, 32'h0000_001F);
        repeat (3) @(posedge clk);
        bus(CTRL_ADDR, 1'b1, 32'h0000_0007);
        @(posedge clk);
        chk(watchdogActive, 1'b1);
        bus(CTRL_ADDR, 1'b1, 32'h0000_001F);
        repeat (2) @(posedge clk);
        bus(CTRL_ADDR, 1'b1, 32'h0000_0005);
        rd_chk(CTRL_ADDR, 32'h0000_0005);
        chk(watchdogActive, 1'b0);
        $display("test unlock sequence done");
        bus(CTRL_ADDR, 1'b1, 32'h0000_0000);
        sawReset = 1'b0;
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        chk(hreadyout, 1'b0);
        ce <= 1'b1;
        repeat (100) @(posedge clk);
        chk(sawReset, 1'b0);
        $display("test disabled done");
        // Every select code, timed from the enabling write to the reset request
        for (int s = 0; s < 8; s++) begin
            do_reset();
            pulse_restart();
            bus(CTRL_ADDR, 1'b1, 32'h0000_0008 | s);
            n = 0;
            while (deviceReset !== 1'b1 && n < 4000) begin @(posedge clk); n++; end
            chk_win(n, ((BASE << s) * 9) / 10, ((BASE << s) * 9) / 10 + 10);
        end
        $display("test timeout codes done");
        do_reset();
        bus(CTRL_ADDR, 1'b1, 32'h0000_0008);
        sawReset = 1'b0;
        repeat (12) begin pulse_restart(); repeat (6) @(posedge clk); end
        chk(sawReset, 1'b0);
        n = 0;
        while (deviceReset !== 1'b1 && n < 40) begin @(posedge clk); n++; end
        chk_win(n, 1, 20);
        // Expiry note, open window count, then a write-one clear once disabled
        rd_chk(STAT_ADDR, 32'h0000_0001);
        bus(CTRL_ADDR, 1'b1, 32'h0000_0018);
        rd_chk(STAT_ADDR, 32'h0000_000B);
        bus(CTRL_ADDR, 1'b1, 32'h0000_0000);
        repeat (20) @(posedge clk);
        bus(STAT_ADDR, 1'b1, 32'h0000_0001);
        rd_chk(STAT_ADDR, 32'h0000_0000);
        $display("test restart done");
        close_out();
    end

    // Longest path is the select sweep, about 4000 cycles
    initial begin
        #3_000_000;
        miscompares++;
        close_out();
    end
endmodule

bind wrt_watchdog_reset_timer wrt_watchdog_reset_timer_properties u_wrt_watchdog_reset_timer_properties (
    .clk(clk), .rstn(rstn), .ce(ce), .wdtOscClk(wdtOscClk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .restartInstr(restartInstr),
    .deviceReset(deviceReset), .watchdogActive(watchdogActive));
`default_nettype wire
